// ---- src/svrd_pkg.sv ----
// Purpose: Constants for the serial voltage link rail-address and code encoder
// Assumes: One clock at 250 MHz, asynchronous active-high reset
// Notes:   Codes and addresses are the link's field values
`default_nettype none

package svrd_pkg;
  // ==========================================================================
  // Field widths
  localparam int ADDR_W = 4;
  localparam int CODE_W = 8;

  // ==========================================================================
  // Rail addresses and their reserved neighbours
  localparam logic [3:0] ADDR_CORE     = 4'h0;
  localparam logic [3:0] ADDR_MEM_A    = 4'h2;
  localparam logic [3:0] ADDR_MEM_B    = 4'h4;
  localparam logic [3:0] ADDR_NEIGHBOR = 4'h1;

  // ==========================================================================
  // Voltage code map
  localparam logic [7:0] CODE_OFF      = 8'h00;
  localparam logic [7:0] CODE_UNUSED_HI = 8'h32;
  localparam logic [7:0] CODE_BASE     = 8'h33;
  localparam logic [7:0] CODE_TOP      = 8'hFF;
  localparam logic [7:0] CODE_MEM_FIX  = 8'h47;
  localparam logic [7:0] REG_VOUT_MAX  = 8'h30;
  localparam logic [7:0] MAX_RESET     = 8'hFF;
  localparam logic [7:0] CMD_SET_FAST  = 8'h01;
  localparam logic [7:0] CMD_SET_REG   = 8'h22;

  // Millivolt figures of the map
  localparam int MV_BASE = 1000;
  localparam int MV_STEP = 10;

  // ==========================================================================
  // Rail selectors
  typedef enum logic [1:0] {
    SVRD_RAIL_CORE  = 2'b00,
    SVRD_RAIL_MEM_A = 2'b01,
    SVRD_RAIL_MEM_B = 2'b10
  } svrd_rail_t;
endpackage : svrd_pkg

`default_nettype wire

// ---- src/svrd_encoder.sv ----
// Purpose: Processor-side encoder of rail address and voltage code packets
// Assumes: Requests synchronous to clk_i; the regulator decodes the fields
// Notes:   One packet per accepted request, held in flops until the next
`default_nettype none

module svrd_encoder
  import svrd_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Request from power management
  input  wire logic                     req_valid_i,
  input  wire svrd_pkg::svrd_rail_t     req_rail_i,
  input  wire logic                     req_off_i,
  input  wire logic [15:0]              req_mv_i,
  input  wire logic                     max_valid_i,
  input  wire logic [svrd_pkg::CODE_W-1:0] max_code_i,
  output logic                          req_ready_o,
  output logic                          req_reject_o,
  // Packet towards the link
  output logic                          pkt_valid_o,
  output logic [svrd_pkg::ADDR_W-1:0]   pkt_addr_o,
  output logic [svrd_pkg::CODE_W-1:0]   pkt_cmd_o,
  output logic [svrd_pkg::CODE_W-1:0]   pkt_payload_o,
  output logic [svrd_pkg::CODE_W-1:0]   max_code_o
);
  import svrd_pkg::*;

  // ==========================================================================
  // Voltage to code conversion
  logic [15:0] mv_span;
  logic [7:0]  next_code;
  logic        code_bad;
  logic        above_max;

  always_comb
  begin
    mv_span   = req_mv_i - 16'(MV_BASE);
    code_bad  = 1'b0;
    next_code = CODE_OFF;
    if (req_off_i)
    begin
      next_code = CODE_OFF;
    end
    else if (req_rail_i != SVRD_RAIL_CORE)
    begin
      next_code = CODE_MEM_FIX;
    end
    else if (req_mv_i < 16'(MV_BASE)
             || (mv_span / 16'(MV_STEP)) > 16'(CODE_TOP - CODE_BASE))
    begin
      code_bad = 1'b1;
    end
    else
    begin
      // Rounds down so the rail never exceeds the request
      next_code = CODE_BASE + 8'(mv_span / 16'(MV_STEP));
    end
  end

  // Off never counts against the maximum
  assign above_max = (next_code > max_code_o) && !req_off_i;

  // ==========================================================================
  // Maximum code held for the regulator register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      max_code_o <= MAX_RESET;
    else if (max_valid_i && !req_valid_i)
      max_code_o <= max_code_i;
  end

  assign req_ready_o = 1'b1;

  // ==========================================================================
  // Packet register
  logic [3:0] next_addr;

  always_comb
  begin
    unique case (req_rail_i)
      SVRD_RAIL_MEM_A: next_addr = ADDR_MEM_A;
      SVRD_RAIL_MEM_B: next_addr = ADDR_MEM_B;
      default:         next_addr = ADDR_CORE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pkt_valid_o   <= 1'b0;
      req_reject_o  <= 1'b0;
      pkt_addr_o    <= ADDR_CORE;
      pkt_cmd_o     <= CMD_SET_FAST;
      pkt_payload_o <= CODE_OFF;
    end
    else
    begin
      pkt_valid_o  <= 1'b0;
      req_reject_o <= 1'b0;
      if (req_valid_i)
      begin
        if (code_bad || above_max)
          req_reject_o <= 1'b1;
        else
        begin
          pkt_valid_o   <= 1'b1;
          pkt_addr_o    <= next_addr;
          pkt_cmd_o     <= CMD_SET_FAST;
          pkt_payload_o <= next_code;
        end
      end
      else if (max_valid_i)
      begin
        // Maximum goes to ADDR_CORE only; the caller cannot send it to another rail
        pkt_valid_o   <= 1'b1;
        pkt_addr_o    <= ADDR_CORE;
        pkt_cmd_o     <= CMD_SET_REG;
        pkt_payload_o <= max_code_i;
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_even_addr;
    @(posedge clk_i) disable iff (rst_i)
    pkt_valid_o |-> (pkt_addr_o[0] == 1'b0 && pkt_addr_o <= ADDR_MEM_B);
  endproperty
  a_even_addr: assert property (p_even_addr) else $error("odd or unknown rail address");

  property p_no_unused_code;
    @(posedge clk_i) disable iff (rst_i)
    (pkt_valid_o && pkt_cmd_o == CMD_SET_FAST)
      |-> (pkt_payload_o == CODE_OFF || pkt_payload_o >= CODE_BASE);
  endproperty
  a_no_unused_code: assert property (p_no_unused_code) else $error("unused code sent");

  property p_mem_fixed;
    @(posedge clk_i) disable iff (rst_i)
    (pkt_valid_o && pkt_cmd_o == CMD_SET_FAST && pkt_addr_o != ADDR_CORE
     && pkt_payload_o != CODE_OFF) |-> pkt_payload_o == CODE_MEM_FIX;
  endproperty
  a_mem_fixed: assert property (p_mem_fixed) else $error("memory rail code varied");

  property p_under_max;
    @(posedge clk_i) disable iff (rst_i)
    (pkt_valid_o && pkt_cmd_o == CMD_SET_FAST) |-> pkt_payload_o <= $past(max_code_o);
  endproperty
  a_under_max: assert property (p_under_max) else $error("code above maximum sent");

  property p_linear;
    @(posedge clk_i) disable iff (rst_i)
    (req_valid_i && !req_off_i && req_rail_i == SVRD_RAIL_CORE && !code_bad && !above_max)
      |=> pkt_valid_o && (16'(pkt_payload_o - CODE_BASE) * 16'(MV_STEP) + 16'(MV_BASE)
          <= $past(req_mv_i));
  endproperty
  a_linear: assert property (p_linear) else $error("code not on 10 mV map");

  property p_rail_addr;
    @(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_rail_i == SVRD_RAIL_MEM_A && !code_bad && !above_max)
      |=> pkt_addr_o == ADDR_MEM_A;
  endproperty
  a_rail_addr: assert property (p_rail_addr) else $error("wrong rail address");

  property p_one_packet;
    @(posedge clk_i) disable iff (rst_i)
    req_valid_i |=> (pkt_valid_o != req_reject_o);
  endproperty
  a_one_packet: assert property (p_one_packet) else $error("request lost or doubled");

  property p_payload_hold;
    @(posedge clk_i) disable iff (rst_i)
    (!req_valid_i && !max_valid_i) |=> $stable(pkt_payload_o) && $stable(pkt_addr_o);
  endproperty
  a_payload_hold: assert property (p_payload_hold) else $error("payload byte changed");

  property p_off_code;
    @(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_off_i) |=> pkt_valid_o && pkt_payload_o == CODE_OFF;
  endproperty
  a_off_code: assert property (p_off_code) else $error("off request not sent as off code");

  property p_reject_low;
    @(posedge clk_i) disable iff (rst_i)
    (req_valid_i && !req_off_i && req_rail_i == SVRD_RAIL_CORE && req_mv_i < 16'(MV_BASE))
      |=> req_reject_o && !pkt_valid_o;
  endproperty
  a_reject_low: assert property (p_reject_low) else $error("request below map sent");

  // Floor rounding: the next step up must already exceed the request
  property p_linear_ceiling;
    @(posedge clk_i) disable iff (rst_i)
    (req_valid_i && !req_off_i && req_rail_i == SVRD_RAIL_CORE && !code_bad && !above_max)
      |=> (16'(pkt_payload_o - CODE_BASE) * 16'(MV_STEP) + 16'(MV_BASE) + 16'(MV_STEP)
          > $past(req_mv_i));
  endproperty
  a_linear_ceiling: assert property (p_linear_ceiling) else $error("code too low");

  property p_max_load;
    @(posedge clk_i) disable iff (rst_i)
    (max_valid_i && !req_valid_i)
      |=> max_code_o == $past(max_code_i) && pkt_valid_o && pkt_cmd_o == CMD_SET_REG;
  endproperty
  a_max_load: assert property (p_max_load) else $error("maximum not loaded");

  property p_byte_cmd;
    @(posedge clk_i) disable iff (rst_i)
    pkt_valid_o |-> (pkt_cmd_o == CMD_SET_FAST || pkt_cmd_o == CMD_SET_REG);
  endproperty
  a_byte_cmd: assert property (p_byte_cmd) else $error("unknown command byte");

endmodule // svrd_encoder

`default_nettype wire

// ---- sim/svrd_vr_model.sv ----
// Purpose: Regulator-side model decoding rail address and code packets
// Assumes: Packet fields from svrd_encoder on one clock
// Notes:   Answers at once; no slow or faulty mode is commanded
`default_nettype none

module svrd_vr_model
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Packet from the link
  input  wire logic       pkt_valid_i,
  input  wire logic [3:0] pkt_addr_i,
  input  wire logic [7:0] pkt_cmd_i,
  input  wire logic [7:0] pkt_payload_i,
  // Decode results
  output logic            hit_o,
  output logic            nsup_o
);
  import svrd_pkg::*;
  logic [7:0] vmax;

  // ====
  // Decode; odd neighbours stay reserved, one address per rail
  assign hit_o = pkt_valid_i
    && (pkt_addr_i inside {ADDR_CORE, ADDR_MEM_A, ADDR_MEM_B});
  assign nsup_o = hit_o && pkt_cmd_i == CMD_SET_FAST && pkt_payload_i > vmax;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      vmax <= MAX_RESET;
    else if (hit_o && pkt_cmd_i == CMD_SET_REG)
      vmax <= pkt_payload_i;
  end
endmodule // svrd_vr_model

`default_nettype wire

// ---- sim/test_serial_vid_rail_decode.sv ----
// Purpose: Self-checking bench of the rail address and code encoder
// Assumes: Inputs driven at the falling edge, seed fixed
// Notes:   Expected codes worked out here from the millivolt map
`default_nettype none

module test_serial_vid_rail_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import svrd_pkg::*;
  logic clk, rst, rv, off, mvld, ready, rej, pv, hit, nsup;
  svrd_rail_t rail;
  logic [15:0] mv;
  logic [7:0] mcode, cmd, pay, max_q, mx;
  logic [3:0] addr;
  int fail_count, checked;

  svrd_encoder u_dut (.clk_i(clk), .rst_i(rst), .req_valid_i(rv), .req_rail_i(rail),
    .req_off_i(off), .req_mv_i(mv), .max_valid_i(mvld), .max_code_i(mcode),
    .req_ready_o(ready), .req_reject_o(rej), .pkt_valid_o(pv), .pkt_addr_o(addr),
    .pkt_cmd_o(cmd), .pkt_payload_o(pay), .max_code_o(max_q));
  svrd_vr_model u_vr (.clk_i(clk), .rst_i(rst), .pkt_valid_i(pv), .pkt_addr_i(addr),
    .pkt_cmd_i(cmd), .pkt_payload_i(pay), .hit_o(hit), .nsup_o(nsup));

  always #2 clk = ~clk;

  // ====
  // Shared tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Valid left high so back-to-back calls present one request per clock
  task automatic req(input logic [1:0] r, input logic o, input logic [15:0] m);
    int c;
    logic j;
    rv = 1'b1; mvld = 1'b0; rail = svrd_rail_t'(r); off = o; mv = m;
    @(negedge clk);
    c = (m < 16'd1000) ? 999 : 51 + (int'(m) - 1000) / 10;
    if (o) c = 0;
    else if (r != 2'd0) c = 'h47;
    j = c > int'(mx);
    chk(8'(rej), 8'(j));
    chk(8'(pv), 8'(!j));
    if (!j)
    begin
      chk(8'(addr), {3'h0, r, 1'b0});
      chk(pay, c[7:0]);
      chk(cmd, CMD_SET_FAST);
      chk(8'({hit, nsup}), 8'h02);
    end
  endtask

  task automatic setmax(input logic [7:0] m);
    rv = 1'b0; mvld = 1'b1; mcode = m;
    @(negedge clk);
    mx = m;
    chk({pv, addr, 3'h0}, 8'h80);
    chk(cmd, CMD_SET_REG);
    chk(pay, m);
    chk(max_q, m);
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ====
  // Main sequence
  initial
  begin
    clk = 0; rst = 1; rv = 0; off = 0; mvld = 0; mv = 0; mcode = 0;
    rail = SVRD_RAIL_CORE; mx = 8'hFF; fail_count = 0; checked = 0;
    void'($urandom(32'h1dfb));
    repeat (10) @(negedge clk);
    rst = 0;
    chk(max_q, 8'hFF);
    chk(8'(ready), 8'h01);
    for (int r = 0; r < 3; r++) req(r[1:0], 1'b1, 16'd0);
    req(0, 0, 1000); req(0, 0, 3040); req(0, 0, 3050); req(0, 0, 999);
    req(0, 0, 1205); req(1, 0, 5000); req(2, 0, 0);
    setmax(8'h80); req(0, 0, 2000); req(0, 0, 1770); req(0, 0, 1780);
    setmax(8'h40); req(1, 0, 0); req(2, 1, 0); setmax(8'hFF);
    $display("test corner done");
    repeat (200)
      if ($urandom_range(0, 7) == 0) setmax(8'($urandom_range(51, 255)));
      else req(2'($urandom_range(0, 2)), $urandom_range(0, 9) == 0,
        16'($urandom_range(900, 3100)));
    $display("test random done");
    summarize();
  end

  initial
  begin
    #8000;
    fail_count++;
    summarize();
  end
endmodule // test_serial_vid_rail_decode

`default_nettype wire
